// [adc_conversion_control.sv]
`timescale 1ns/1ps
// Overview of operation
// - Converter keeps running in standby sleep only with standby_run set.
// - Resolution select 0 passes the full 10-bit value on.
// - Resolution select 1 keeps the upper 8 bits, dropping the two lowest.
// - Enable bit 0 disables the converter, 1 enables it.
// - Accumulate 2^code samples per conversion; code 0 single, 6 gives 64, 7 reserved.
// - Capacitance select 0 normal, 1 reduced sampling capacitance.
// - Reference code 0 internal, 1 supply, others reserved.
// - Reference change during conversion applies only once the result is ready.
// - Converter clock is peripheral clock divided by 2^(code+1).
// - Settling delay 0,16,32,64,128,256 converter cycles on init or reference change.
// - Total initial delay adds a fixed 11-cycle pipeline delay.
// - Auto delay variation increments the sample spacing field after each sample.
// - With auto variation the spacing field wraps from 0xF to 0x0.
// - Wait 0 to 15 cycles between consecutive samples, only while accumulating.
// - Window comparison uses the 16-bit result and 16-bit thresholds.
// - Window modes: none, below, above, strictly inside, not strictly inside.
// - Hold sample for length plus 2 cycles, then 11 pipeline cycles to finish.
// - Set the result-ready flag when a conversion completes.
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // System and trigger
  input  wire logic              standbySleep,
  input  wire logic              startTrigger,
  // Analog converter side
  input  wire logic [9:0]        rawSample,
  output logic                   converterOn,
  output logic                   sampleCapReduced,
  output logic      [1:0]        refSelect,
  output logic                   sampleHold,
  output logic                   adcClkTick,
  // Results and events
  output logic      [15:0]       conversionResult,
  output logic                   resultReadyPulse,
  output logic                   windowHitPulse,
  output logic                   busy,
  output logic                   irq
);

  logic [7:0]  mainCtrl_ff, nxt_mainCtrl;
  logic [7:0]  accumCfg_ff, nxt_accumCfg;
  logic [7:0]  refClkCfg_ff, nxt_refClkCfg;
  logic [7:0]  delayCfg_ff, nxt_delayCfg;
  logic [7:0]  windowCfg_ff, nxt_windowCfg;
  logic [7:0]  sampLenCfg_ff, nxt_sampLenCfg;
  logic [1:0]  irqMask_ff, nxt_irqMask;
  logic [1:0]  irqStatus_ff, nxt_irqStatus;
  logic [15:0] winLow_ff, nxt_winLow;
  logic [15:0] winHigh_ff, nxt_winHigh;
  logic        ack_ff, nxt_ack;
  logic [31:0] readdata_ff, nxt_readdata;
  logic        startReq_ff, nxt_startReq;

  conv_state_t state_ff, nxt_state;
  logic [8:0]  cnt_ff, nxt_cnt;
  logic [6:0]  left_ff, nxt_left;
  logic [15:0] accum_ff, nxt_accum;
  logic [15:0] result_ff, nxt_result;
  logic        result_ready_flag_ff, nxt_result_ready_flag;
  logic        winHit_ff, nxt_winHit;
  logic [1:0]  refActive_ff, nxt_refActive;
  logic        initPending_ff, nxt_initPending;
  logic        activePrev_ff, nxt_activePrev;
  logic [7:0]  adc_clk_divider_ff, nxt_adc_clk_divider;
  logic [9:0]  rawMeta_ff, rawSync_ff;

  logic [4:0]  regIdx;
  logic        idxAligned, wrCommit, rdCommit, active, tick;
  logic [7:0]  prescLimit;
  logic [2:0]  accCode, initCode;
  logic [6:0]  sampleTotal;
  logic [8:0]  initTotal, holdTotal;
  logic [3:0]  spacing;
  logic [15:0] sampleVal, sumVal;
  logic        winMatch, convDone, autoStep, launch;

  assign regIdx     = address[ADDR_W-1:2];
  assign idxAligned = (address[1:0] == 2'h0);
  assign wrCommit   = write & ack_ff & idxAligned;
  assign rdCommit   = read & ack_ff & idxAligned;
  assign waitrequest = (read | write) & ~ack_ff;

  // Converter runs when enabled, and in standby only with run-in-standby set
  assign active = mainCtrl_ff[MAIN_ENABLE_BIT] &
                  (~standbySleep | mainCtrl_ff[MAIN_STBYRUN_BIT]);

  // Divide by 2^(code+1): tick every (2 << code) peripheral cycles
  assign prescLimit = 8'((9'h002 << refClkCfg_ff[ADC_CLK_DIVIDER_LSB +: 3]) - 9'h001);
  assign tick       = active & (adc_clk_divider_ff == prescLimit);

  // Reserved codes fall back to the nearest defined code
  assign accCode  = (accumCfg_ff[ACC_LSB +: 3] > ACC_MAX_CODE) ?
                    ACC_MAX_CODE : accumCfg_ff[ACC_LSB +: 3];
  assign initCode = (delayCfg_ff[INIT_SETTLE_DELAY_LSB +: 3] > INIT_MAX_CODE) ?
                    INIT_MAX_CODE : delayCfg_ff[INIT_SETTLE_DELAY_LSB +: 3];
  assign sampleTotal = 7'(8'h01 << accCode);
  assign initTotal   = ((initCode == 3'h0) ? 9'h000 : (INIT_UNIT << initCode))
                       + PIPE_CYCLES;
  assign holdTotal   = {4'h0, sampLenCfg_ff[SAMPLE_HOLD_LENGTH_LSB +: 5]} + HOLD_BASE;
  assign spacing     = delayCfg_ff[SPACING_LSB +: 4];

  assign sampleVal = mainCtrl_ff[MAIN_RESOLUTION_SELECT_BIT] ?
                     {8'h00, rawSync_ff[9:2]} :
                     {6'h00, rawSync_ff};
  assign sumVal    = accum_ff + sampleVal;

  assign convDone = (state_ff == ST_CONVERT) & tick & (cnt_ff == 9'h001) &
                    (left_ff == 7'h01);
  assign autoStep = (state_ff == ST_CONVERT) & tick & (cnt_ff == 9'h001) &
                    delayCfg_ff[AUTOVARY_BIT];
  assign launch   = (state_ff == ST_IDLE) & active & ~initPending_ff & startReq_ff &
                    (refClkCfg_ff[REF_LSB +: 2] == refActive_ff);

  // Window check on the value about to be stored
  always_comb begin
    case (windowCfg_ff[WINMODE_LSB +: 3])
      WIN_BELOW:   winMatch = sumVal < winLow_ff;
      WIN_ABOVE:   winMatch = sumVal > winHigh_ff;
      WIN_INSIDE:  winMatch = (sumVal > winLow_ff) & (sumVal < winHigh_ff);
      WIN_OUTSIDE: winMatch = ~((sumVal > winLow_ff) & (sumVal < winHigh_ff));
      default:     winMatch = 1'b0;
    endcase
  end

  // Register file and bus slave
  always_comb begin
    nxt_mainCtrl   = mainCtrl_ff;
    nxt_accumCfg   = accumCfg_ff;
    nxt_refClkCfg  = refClkCfg_ff;
    nxt_delayCfg   = delayCfg_ff;
    nxt_windowCfg  = windowCfg_ff;
    nxt_sampLenCfg = sampLenCfg_ff;
    nxt_irqMask    = irqMask_ff;
    nxt_irqStatus  = irqStatus_ff;
    nxt_winLow     = winLow_ff;
    nxt_winHigh    = winHigh_ff;
    nxt_startReq   = startReq_ff;
    nxt_ack        = (read | write) & ~ack_ff;
    nxt_readdata   = readdata_ff;
    if (nxt_ack && read) begin
      nxt_readdata = 32'h00000000;
      if (idxAligned) begin
        case (regIdx)
          IDX_MAIN:       nxt_readdata[7:0] = mainCtrl_ff & 8'h85;
          IDX_ACCUM:      nxt_readdata[7:0] = accumCfg_ff & 8'h07;
          IDX_REFCLK:     nxt_readdata[7:0] = refClkCfg_ff & 8'h77;
          IDX_DELAY:      nxt_readdata[7:0] = delayCfg_ff;
          IDX_WINDOW:     nxt_readdata[7:0] = windowCfg_ff & 8'h07;
          IDX_SAMPLE_HOLD_LENGTH:    nxt_readdata[7:0] = sampLenCfg_ff & 8'h1F;
          IDX_COMMAND:    nxt_readdata[CMD_START_BIT] = busy;
          IDX_IRQ_MASK:   nxt_readdata[1:0] = irqMask_ff;
          IDX_IRQ_STATUS: nxt_readdata[1:0] = irqStatus_ff;
          IDX_RESULT:     nxt_readdata[15:0] = result_ff;
          IDX_WIN_LOW:    nxt_readdata[15:0] = winLow_ff;
          IDX_WIN_HIGH:   nxt_readdata[15:0] = winHigh_ff;
          default:        nxt_readdata = 32'h00000000;
        endcase
      end
    end
    if (wrCommit && byteenable[0]) begin
      case (regIdx)
        IDX_MAIN:     nxt_mainCtrl   = writedata[7:0];
        IDX_ACCUM:    nxt_accumCfg   = writedata[7:0];
        IDX_REFCLK:   nxt_refClkCfg  = writedata[7:0];
        IDX_DELAY:    nxt_delayCfg   = writedata[7:0];
        IDX_WINDOW:   nxt_windowCfg  = writedata[7:0];
        IDX_SAMPLE_HOLD_LENGTH:  nxt_sampLenCfg = writedata[7:0];
        IDX_IRQ_MASK: nxt_irqMask    = writedata[1:0];
        IDX_COMMAND: begin
          if (writedata[CMD_START_BIT]) begin
            nxt_startReq = 1'b1;
          end
        end
        IDX_WIN_LOW:  nxt_winLow[7:0]  = writedata[7:0];
        IDX_WIN_HIGH: nxt_winHigh[7:0] = writedata[7:0];
        default: ;
      endcase
    end
    if (wrCommit && byteenable[1]) begin
      case (regIdx)
        IDX_WIN_LOW:  nxt_winLow[15:8]  = writedata[15:8];
        IDX_WIN_HIGH: nxt_winHigh[15:8] = writedata[15:8];
        default: ;
      endcase
    end
    // Spacing field steps after every sample and wraps at 0xF
    if (autoStep) begin
      nxt_delayCfg[SPACING_LSB +: 4] = spacing + 4'h1;
    end
    if (startTrigger) begin
      nxt_startReq = 1'b1;
    end
    if (launch) begin
      nxt_startReq = startTrigger;
    end
    if (!mainCtrl_ff[MAIN_ENABLE_BIT]) begin
      nxt_startReq = 1'b0;
    end
    // Read clears status; a new event in the same cycle wins
    if (rdCommit && (regIdx == IDX_IRQ_STATUS)) begin
      nxt_irqStatus = 2'h0;
    end
    if (result_ready_flag_ff) begin
      nxt_irqStatus[IRQ_RESULT_READY_FLAG_BIT] = 1'b1;
    end
    if (winHit_ff) begin
      nxt_irqStatus[IRQ_WINDOW_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mainCtrl_ff   <= RST_REG8;
      accumCfg_ff   <= RST_REG8;
      refClkCfg_ff  <= RST_REG8;
      delayCfg_ff   <= RST_REG8;
      windowCfg_ff  <= RST_REG8;
      sampLenCfg_ff <= RST_REG8;
      irqMask_ff    <= 2'h0;
      irqStatus_ff  <= 2'h0;
      winLow_ff     <= RST_REG16;
      winHigh_ff    <= RST_REG16;
      ack_ff        <= 1'b0;
      readdata_ff   <= 32'h00000000;
      startReq_ff   <= 1'b0;
    end else begin
      mainCtrl_ff   <= nxt_mainCtrl;
      accumCfg_ff   <= nxt_accumCfg;
      refClkCfg_ff  <= nxt_refClkCfg;
      delayCfg_ff   <= nxt_delayCfg;
      windowCfg_ff  <= nxt_windowCfg;
      sampLenCfg_ff <= nxt_sampLenCfg;
      irqMask_ff    <= nxt_irqMask;
      irqStatus_ff  <= nxt_irqStatus;
      winLow_ff     <= nxt_winLow;
      winHigh_ff    <= nxt_winHigh;
      ack_ff        <= nxt_ack;
      readdata_ff   <= nxt_readdata;
      startReq_ff   <= nxt_startReq;
    end
  end

  // Conversion sequencer
  always_comb begin
    nxt_state       = state_ff;
    nxt_cnt         = cnt_ff;
    nxt_left        = left_ff;
    nxt_accum       = accum_ff;
    nxt_result      = result_ff;
    nxt_result_ready_flag      = 1'b0;
    nxt_winHit      = 1'b0;
    nxt_refActive   = refActive_ff;
    nxt_initPending = initPending_ff;
    nxt_activePrev  = active;
    nxt_adc_clk_divider       = tick ? 8'h00 : (active ? adc_clk_divider_ff + 8'h01 : 8'h00);
    if (active && !activePrev_ff) begin
      nxt_initPending = 1'b1;
    end
    // Reference follows the register only between conversions
    if ((state_ff == ST_IDLE || convDone) &&
        (refClkCfg_ff[REF_LSB +: 2] != refActive_ff)) begin
      nxt_refActive   = refClkCfg_ff[REF_LSB +: 2];
      nxt_initPending = 1'b1;
    end
    case (state_ff)
      ST_IDLE: begin
        if (active && initPending_ff) begin
          nxt_state = ST_SETTLE;
          nxt_cnt   = initTotal;
        end else if (launch) begin
          nxt_state = ST_SAMPLE;
          nxt_cnt   = holdTotal;
          nxt_left  = sampleTotal;
          nxt_accum = 16'h0000;
        end
      end
      ST_SETTLE: begin
        if (tick) begin
          if (cnt_ff == 9'h001) begin
            nxt_state       = ST_IDLE;
            nxt_initPending = 1'b0;
          end else begin
            nxt_cnt = cnt_ff - 9'h001;
          end
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          if (cnt_ff == 9'h001) begin
            nxt_state = ST_CONVERT;
            nxt_cnt   = PIPE_CYCLES;
          end else begin
            nxt_cnt = cnt_ff - 9'h001;
          end
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          if (cnt_ff != 9'h001) begin
            nxt_cnt = cnt_ff - 9'h001;
          end else if (left_ff == 7'h01) begin
            nxt_state  = ST_IDLE;
            nxt_result = sumVal;
            nxt_result_ready_flag = 1'b1;
            nxt_winHit = winMatch;
          end else begin
            nxt_accum = sumVal;
            nxt_left  = left_ff - 7'h01;
            if (spacing == 4'h0) begin
              nxt_state = ST_SAMPLE;
              nxt_cnt   = holdTotal;
            end else begin
              nxt_state = ST_SPACE;
              nxt_cnt   = {5'h00, spacing};
            end
          end
        end
      end
      ST_SPACE: begin
        if (tick) begin
          if (cnt_ff == 9'h001) begin
            nxt_state = ST_SAMPLE;
            nxt_cnt   = holdTotal;
          end else begin
            nxt_cnt = cnt_ff - 9'h001;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Clearing enable abandons any conversion in progress
    if (!mainCtrl_ff[MAIN_ENABLE_BIT]) begin
      nxt_state       = ST_IDLE;
      nxt_initPending = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff       <= ST_IDLE;
      cnt_ff         <= 9'h000;
      left_ff        <= 7'h00;
      accum_ff       <= RST_REG16;
      result_ff      <= RST_REG16;
      result_ready_flag_ff      <= 1'b0;
      winHit_ff      <= 1'b0;
      refActive_ff   <= 2'h0;
      initPending_ff <= 1'b0;
      activePrev_ff  <= 1'b0;
      adc_clk_divider_ff       <= 8'h00;
      rawMeta_ff     <= 10'h000;
      rawSync_ff     <= 10'h000;
    end else begin
      state_ff       <= nxt_state;
      cnt_ff         <= nxt_cnt;
      left_ff        <= nxt_left;
      accum_ff       <= nxt_accum;
      result_ff      <= nxt_result;
      result_ready_flag_ff      <= nxt_result_ready_flag;
      winHit_ff      <= nxt_winHit;
      refActive_ff   <= nxt_refActive;
      initPending_ff <= nxt_initPending;
      activePrev_ff  <= nxt_activePrev;
      adc_clk_divider_ff       <= nxt_adc_clk_divider;
      rawMeta_ff     <= rawSample;
      rawSync_ff     <= rawMeta_ff;
    end
  end

  assign readdata         = readdata_ff;
  assign converterOn      = activePrev_ff;
  assign sampleCapReduced = refClkCfg_ff[CAP_BIT];
  assign refSelect        = (refActive_ff > REF_MAX_CODE) ? REF_MAX_CODE :
                            refActive_ff;
  assign sampleHold       = (state_ff == ST_SAMPLE);
  assign adcClkTick       = tick;
  assign conversionResult = result_ff;
  assign resultReadyPulse = result_ready_flag_ff;
  assign windowHitPulse   = winHit_ff;
  assign busy             = (state_ff != ST_IDLE) || startReq_ff;
  assign irq              = |(irqStatus_ff & irqMask_ff);

endmodule

// [adc_conversion_control_props.sv]
`timescale 1ns/1ps
module adc_conversion_control_props
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // Bus handshake
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  // Converter side
  input wire logic        standbySleep,
  input wire logic        converterOn,
  input wire logic        sampleHold,
  input wire logic        adcClkTick,
  input wire logic [1:0]  refSelect,
  // Results
  input wire logic [15:0] conversionResult,
  input wire logic        resultReadyPulse,
  input wire logic        windowHitPulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest held longer than one cycle");
  ready_pulse_a: assert property (resultReadyPulse |=> !resultReadyPulse)
    else $error("result ready longer than one cycle");
  win_ready_a: assert property (windowHitPulse |-> resultReadyPulse)
    else $error("window hit without result ready");
  hold_len_a: assert property ($rose(sampleHold) |-> sampleHold[*3])
    else $error("sample phase too short");
  hold_gap_a: assert property ($fell(sampleHold) |-> !resultReadyPulse[*8])
    else $error("result ready too soon after sampling");
  tick_gap_a: assert property (adcClkTick |=> !adcClkTick)
    else $error("converter tick faster than half rate");
  ref_defer_a: assert property (!$stable(refSelect) |-> !sampleHold)
    else $error("reference changed while sampling");
  ref_code_a: assert property (refSelect[1] == 1'b0)
    else $error("reference output shows a reserved code");
  result_upd_a: assert property (!$stable(conversionResult) |->
    resultReadyPulse || $past(resultReadyPulse))
    else $error("result changed without completion");
  off_hold_a: assert property (!converterOn && !standbySleep && !$past(standbySleep)
    |-> ##2 !sampleHold)
    else $error("sampling while disabled");

  cover property (resultReadyPulse && windowHitPulse);
  cover property ($rose(sampleHold));
  cover property (!$stable(refSelect));
endmodule

bind adc_conversion_control adc_conversion_control_props chk_i (
  .sys_clk(sys_clk), .resetn(resetn), .read(read), .write(write),
  .waitrequest(waitrequest), .standbySleep(standbySleep),
  .converterOn(converterOn), .sampleHold(sampleHold), .adcClkTick(adcClkTick),
  .refSelect(refSelect), .conversionResult(conversionResult),
  .resultReadyPulse(resultReadyPulse), .windowHitPulse(windowHitPulse)
);

// [adc_conversion_control_tb.sv]
`timescale 1ns/1ps
module adc_conversion_control_tb
  import adc_ctrl_pkg::*;
;
  typedef struct packed {
    logic [7:0]  main, acc, win;
    logic [9:0]  raw;
    logic [15:0] res;
    logic        hit;
  } row_t;
  logic sys_clk, resetn, read, write, standbySleep, startTrigger, hit;
  logic waitrequest, converterOn, sampleCapReduced, sampleHold, adcClkTick;
  logic resultReadyPulse, windowHitPulse, busy, irq;
  logic [ADDR_W-1:0] address;
  logic [31:0]       writedata, readdata, rd;
  logic [3:0]        byteenable;
  logic [9:0]        rawSample;
  logic [1:0]        refSelect;
  logic [15:0]       conversionResult;
  int                n_errors, cmp_count, i, t;
  logic [7:0]        msk [6] = '{8'h85, 8'h07, 8'h77, 8'hFF, 8'h07, 8'h1F};
  row_t rows [11] = '{
    '{8'h01, 8'h00, 8'h00, 10'h2AD, 16'h02AD, 1'b0},
    '{8'h05, 8'h00, 8'h00, 10'h2AD, 16'h00AB, 1'b0},
    '{8'h01, 8'h01, 8'h02, 10'h2AD, 16'h055A, 1'b1},
    '{8'h01, 8'h02, 8'h04, 10'h2AD, 16'h0AB4, 1'b1},
    '{8'h01, 8'h00, 8'h03, 10'h200, 16'h0200, 1'b1},
    '{8'h01, 8'h00, 8'h01, 10'h0FF, 16'h00FF, 1'b1},
    '{8'h01, 8'h00, 8'h01, 10'h100, 16'h0100, 1'b0},
    '{8'h01, 8'h00, 8'h03, 10'h300, 16'h0300, 1'b0},
    '{8'h01, 8'h00, 8'h04, 10'h300, 16'h0300, 1'b1},
    '{8'h05, 8'h06, 8'h00, 10'h3FF, 16'h3FC0, 1'b0},
    '{8'h01, 8'h07, 8'h00, 10'h001, 16'h0040, 1'b0}};

  adc_conversion_control uut (
    .sys_clk(sys_clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .standbySleep(standbySleep),
    .startTrigger(startTrigger), .rawSample(rawSample), .converterOn(converterOn),
    .sampleCapReduced(sampleCapReduced), .refSelect(refSelect),
    .sampleHold(sampleHold), .adcClkTick(adcClkTick),
    .conversionResult(conversionResult), .resultReadyPulse(resultReadyPulse),
    .windowHitPulse(windowHitPulse), .busy(busy), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chkb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  // Starts just after a rising edge, holds until waitrequest is sampled low
  task bus(input logic wr, input logic [4:0] idx, input logic [15:0] d);
    int n;
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {16'h0000, d};
    byteenable <= wr ? 4'h3 : 4'hF;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) n_errors++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wr(input logic [4:0] idx, input logic [7:0] d);
    bus(1'b1, idx, {8'h00, d});
  endtask
  task rdc(input string nm, input logic [4:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 16'h0000);
    chk(nm, {8'h00, e}, rd[15:0]);
  endtask
  task trig;
    startTrigger <= 1'b1;
    @(posedge sys_clk);
    startTrigger <= 1'b0;
  endtask
  task wait_rdy;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (resultReadyPulse !== 1'b1 && t < 20000);
    if (t >= 20000) n_errors++;
    hit = windowHitPulse;
    @(posedge sys_clk);
  endtask
  task tickgap;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (adcClkTick !== 1'b1 && t < 600);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #600000;
    n_errors++;
    final_report();
  end

  initial begin
    resetn = 1'b0; read = 1'b0; write = 1'b0; standbySleep = 1'b0;
    startTrigger = 1'b0; address = '0; writedata = '0; byteenable = 4'h0;
    rawSample = 10'h000; n_errors = 0; cmp_count = 0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    for (i = 0; i < 6; i++) rdc("reset value", i[4:0], 8'h00);
    $display("reset values done");
    bus(1'b1, IDX_WIN_LOW, 16'h0100);
    bus(1'b1, IDX_WIN_HIGH, 16'h0300);
    for (i = 0; i < 11; i++) begin
      wr(IDX_ACCUM, rows[i].acc);
      wr(IDX_WINDOW, rows[i].win);
      wr(IDX_MAIN, rows[i].main);
      rawSample <= rows[i].raw;
      repeat (40) @(posedge sys_clk);
      trig();
      wait_rdy();
      chk("result", rows[i].res, conversionResult);
      chkb("window hit", rows[i].hit, hit);
      $display("row %0d done", i);
    end
    for (i = 0; i < 6; i++) begin
      wr(i[4:0], 8'hFF);
      rdc("access", i[4:0], msk[i]);
    end
    wr(5'h07, 8'hFF);
    rdc("unmapped", 5'h07, 8'h00);
    repeat (4) @(posedge sys_clk);
    chk("reserved ref", 16'h0001, {14'h0000, refSelect});
    for (i = 0; i < 6; i++) wr(i[4:0], 8'h00);
    $display("register access done");
    wr(IDX_MAIN, 8'h01);
    wr(IDX_IRQ_MASK, 8'h01);
    bus(1'b0, IDX_IRQ_STATUS, 16'h0000);
    chkb("irq idle", 1'b0, irq);
    repeat (60) @(posedge sys_clk);
    trig();
    wait_rdy();
    chkb("irq set", 1'b1, irq);
    rdc("status", IDX_IRQ_STATUS, 8'h01);
    chkb("irq cleared", 1'b0, irq);
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_COMMAND, 8'h01);
    wait_rdy();
    chkb("irq masked", 1'b0, irq);
    rdc("status", IDX_IRQ_STATUS, 8'h01);
    $display("interrupt done");
    wr(IDX_DELAY, 8'h1F);
    trig();
    wait_rdy();
    rdc("spacing wrap", IDX_DELAY, 8'h10);
    trig();
    wait_rdy();
    rdc("spacing step", IDX_DELAY, 8'h11);
    $display("auto vary done");
    wr(IDX_SAMPLE_HOLD_LENGTH, 8'h1F);
    wr(IDX_REFCLK, 8'h03);
    repeat (20) @(posedge sys_clk);
    trig();
    repeat (10) @(posedge sys_clk);
    chkb("busy", 1'b1, busy);
    wr(IDX_REFCLK, 8'h13);
    chk("ref held", 16'h0000, {14'h0000, refSelect});
    wait_rdy();
    repeat (4) @(posedge sys_clk);
    chk("ref applied", 16'h0001, {14'h0000, refSelect});
    $display("reference defer done");
    for (i = 0; i < 8; i++) begin
      wr(IDX_REFCLK, i[7:0]);
      tickgap();
      tickgap();
      tickgap();
      chk("divide", 16'h0002 << i, t[15:0]);
    end
    $display("prescaler done");
    standbySleep <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chkb("standby off", 1'b0, converterOn);
    wr(IDX_MAIN, 8'h81);
    repeat (3) @(posedge sys_clk);
    chkb("standby run", 1'b1, converterOn);
    standbySleep <= 1'b0;
    wr(IDX_MAIN, 8'h00);
    repeat (3) @(posedge sys_clk);
    chkb("disabled", 1'b0, converterOn);
    wr(IDX_REFCLK, 8'h40);
    chkb("cap reduced", 1'b1, sampleCapReduced);
    $display("standby done");
    wr(IDX_DELAY, 8'h20);
    wr(IDX_MAIN, 8'h01);
    t = 0;
    repeat (80) begin
      @(posedge sys_clk);
      if (busy === 1'b1) t++;
    end
    chk("settle", 16'h0036, t[15:0]);
    $display("settle done");
    final_report();
  end
endmodule

// [adc_ctrl_pkg.sv]
package adc_ctrl_pkg;

  // Avalon byte address width; each register takes one word at index * 4
  localparam int          ADDR_W         = 7;
  localparam logic [4:0]  IDX_MAIN       = 5'h00;
  localparam logic [4:0]  IDX_ACCUM      = 5'h01;
  localparam logic [4:0]  IDX_REFCLK     = 5'h02;
  localparam logic [4:0]  IDX_DELAY      = 5'h03;
  localparam logic [4:0]  IDX_WINDOW     = 5'h04;
  localparam logic [4:0]  IDX_SAMPLE_HOLD_LENGTH    = 5'h05;
  localparam logic [4:0]  IDX_COMMAND    = 5'h08;
  localparam logic [4:0]  IDX_IRQ_MASK   = 5'h0A;
  localparam logic [4:0]  IDX_IRQ_STATUS = 5'h0B;
  localparam logic [4:0]  IDX_RESULT     = 5'h10;
  localparam logic [4:0]  IDX_WIN_LOW    = 5'h12;
  localparam logic [4:0]  IDX_WIN_HIGH   = 5'h14;

  // Field positions
  localparam int MAIN_ENABLE_BIT   = 0;
  localparam int MAIN_RESOLUTION_SELECT_BIT   = 2;
  localparam int MAIN_STBYRUN_BIT  = 7;
  localparam int ACC_LSB           = 0;
  localparam int ADC_CLK_DIVIDER_LSB         = 0;
  localparam int REF_LSB           = 4;
  localparam int CAP_BIT           = 6;
  localparam int SPACING_LSB       = 0;
  localparam int AUTOVARY_BIT      = 4;
  localparam int INIT_SETTLE_DELAY_LSB       = 5;
  localparam int WINMODE_LSB       = 0;
  localparam int SAMPLE_HOLD_LENGTH_LSB       = 0;
  localparam int CMD_START_BIT     = 0;
  localparam int IRQ_RESULT_READY_FLAG_BIT    = 0;
  localparam int IRQ_WINDOW_BIT    = 1;

  // Reset values
  localparam logic [7:0]  RST_REG8       = 8'h00;
  localparam logic [15:0] RST_REG16      = 16'h0000;

  // Codes and timing counts in converter clock cycles
  localparam logic [2:0]  ACC_MAX_CODE   = 3'h6;
  localparam logic [2:0]  INIT_MAX_CODE  = 3'h5;
  localparam logic [1:0]  REF_MAX_CODE   = 2'h1;
  localparam logic [8:0]  INIT_UNIT      = 9'h008;
  localparam logic [8:0]  PIPE_CYCLES    = 9'h00B;
  localparam logic [8:0]  HOLD_BASE      = 9'h002;

  localparam logic [2:0]  WIN_NONE       = 3'h0;
  localparam logic [2:0]  WIN_BELOW      = 3'h1;
  localparam logic [2:0]  WIN_ABOVE      = 3'h2;
  localparam logic [2:0]  WIN_INSIDE     = 3'h3;
  localparam logic [2:0]  WIN_OUTSIDE    = 3'h4;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_SETTLE  = 5'h02,
    ST_SAMPLE  = 5'h04,
    ST_CONVERT = 5'h08,
    ST_SPACE   = 5'h10
  } conv_state_t;

endpackage
